// file: hw/io_port_regs.sv
// Configurable I/O port registers: configuration, data and cell access
// Function
// - Mode, direction and drive-select registers reset to all zeros.
// - Every register bit acts only on the pin of the same position.
// - Mode bit 0 gives processor I/O, 1 gives address output.
// - Only ports E, F and G have a mode-select register.
// - Direction bit 1 makes an output, 0 an input; default input.
// - Ports A, B, C, F drive when direction bit or logic enable is 1.
// - Port D has four pins; only low four direction bits work.
// - Open-drain capable pins: drive bit 1 open drain, 0 push-pull.
// - Slew-capable pins: drive bit 1 fast slew, 0 slow slew.
// - A, B, E, G, D[3:0] open drain; C, F slew; D[7:4] unused.
// - Pin-input read returns the live pin level, not latched.
// - Output latch stores writes, reads back, drives when enabled.
// - Ports A, B: cell read gives cell outputs, write loads unmasked.
// - Mask bit 1 blocks processor loading of its output cell.
// - Ports A, B, C input cells feed logic and are readable.
// - Ports A, B, C, F: enable readback shows 1 for a driving pin, 0 for tri-state.
// - Host reaches registers with plain bus cycles at block offsets.
// - High chip select disables the I/O register block.
`timescale 1ns/1ps
`default_nettype none
module io_port_regs #(
  parameter int PORTS = 7,
  parameter logic [7:0] BLOCK_BASE = 8'h00
) (
  input wire logic ref_clk, // 200 MHz clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic chipSelHigh, // Chip select input, high disables
  input wire io_port_pkg::host_req_t hostReq, // Host read/write cycle
  output logic [7:0] rdData, // Read data, registered
  output logic rdValid, // Read data valid pulse
  input wire logic [PORTS*8-1:0] pinIn, // Pin levels, per port
  input wire logic [PORTS*8-1:0] logicOe, // Logic-array enable terms
  input wire logic [15:0] cellOut, // Output cell outputs, A then B
  input wire logic [23:0] inCellOut, // Input cell outputs A, B, C
  output io_port_pkg::pin_drive_t [PORTS-1:0] pinDrive, // Pin drivers
  output logic [15:0] cellLoadData, // Data for output cells A, B
  output logic [15:0] cellLoadEn, // Per-bit load of output cells
  output logic [23:0] inCellBus // Input cells to logic input bus
);
  import io_port_pkg::*;

  initial begin
    if (PORTS != NUM_PORTS) begin
      $error("io_port_regs: the port map serves seven ports only");
    end
    // The window must not wrap past the top of the address space
    if (32'(BLOCK_BASE) + PORTS * 32'(PORT_STRIDE) > 256) begin
      $error("io_port_regs: BLOCK_BASE leaves no room for the ports");
    end
  end

  // ==========================================================
  // State
  typedef struct packed {
    bus_state_t bus;
    logic [7:0] rdData;
    logic rdValid;
    logic [15:0] cellLoadData;
    logic [15:0] cellLoadEn;
    logic [23:0] inCellBus;
    pin_drive_t [PORTS-1:0] drive;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;

  // ==========================================================
  // Host address decode
  logic [2:0] portIdx;
  logic [3:0] regOfs;
  logic inBlock;
  logic rdStb;
  logic wrStb;
  logic [7:0] offset;

  assign offset = hostReq.addr - BLOCK_BASE;
  assign portIdx = offset[6:4];
  assign regOfs = offset[3:0];
  // Chip select high blocks every access
  assign inBlock = !chipSelHigh && (32'(portIdx) < PORTS)
    && !offset[7];
  // Read taken in an idle cycle; a read wins over a write
  assign rdStb = inBlock && hostReq.rd && (state.bus == BUS_IDLE);
  // Writes commit on the cycle the strobe is seen
  assign wrStb = inBlock && hostReq.wr && !hostReq.rd
    && (state.bus == BUS_IDLE);

  // ==========================================================
  // Register banks
  logic [PORTS*8-1:0] dirFlat;
  logic [PORTS*8-1:0] driveFlat;
  logic [PORTS*8-1:0] modeFlat;
  logic [PORTS*8-1:0] latchFlat;
  logic [15:0] maskFlat;
  logic wrDir;
  logic wrDrive;
  logic wrMode;
  logic wrLatch;
  logic wrMask;

  // Write enable per register kind
  assign wrDir = wrStb && (regOfs == OFS_DIRECTION);
  assign wrDrive = wrStb && (regOfs == OFS_DRIVE_SELECT);
  assign wrMode = wrStb && (regOfs == OFS_MODE_SELECT)
    && (portIdx >= PORT_E);
  assign wrLatch = wrStb && (regOfs == OFS_OUTPUT_LATCH);
  assign wrMask = wrStb && (regOfs == OFS_CELL_MASK)
    && (portIdx <= PORT_B);

  // Configuration zeroed at reset
  port_reg_bank #(.PORTS(PORTS)) dirBank (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wrIdx(portIdx),
    .wrEn(wrDir),
    .wrData(hostReq.wdata),
    .resetVal(CFG_RESET),
    .flat(dirFlat)
  );

  // Drive select, meaning set per port below
  port_reg_bank #(.PORTS(PORTS)) driveBank (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wrIdx(portIdx),
    .wrEn(wrDrive),
    .wrData(hostReq.wdata),
    .resetVal(CFG_RESET),
    .flat(driveFlat)
  );

  // Mode register exists for E, F, G only
  port_reg_bank #(.PORTS(PORTS)) modeBank (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wrIdx(portIdx),
    .wrEn(wrMode),
    .wrData(hostReq.wdata),
    .resetVal(CFG_RESET),
    .flat(modeFlat)
  );

  // Output latch stores host data
  port_reg_bank #(.PORTS(PORTS)) latchBank (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wrIdx(portIdx),
    .wrEn(wrLatch),
    .wrData(hostReq.wdata),
    .resetVal(LATCH_RESET),
    .flat(latchFlat)
  );

  // Cell load mask for ports A and B
  port_reg_bank #(.PORTS(2)) maskBank (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wrIdx(portIdx),
    .wrEn(wrMask),
    .wrData(hostReq.wdata),
    .resetVal(CFG_RESET),
    .flat(maskFlat)
  );

  // ==========================================================
  // Per-port pin logic, bit for bit
  logic [7:0] validMask [PORTS];
  logic [7:0] oeTerm [PORTS];
  logic [7:0] odCap [PORTS];
  logic [7:0] slewCap [PORTS];
  pin_drive_t [PORTS-1:0] driveNow;

  // One copy of the pin logic per port
  genvar p;
  generate
    for (p = 0; p < PORTS; p++) begin : gPort
      // Port D has four pins
      assign validMask[p] = (p == 3) ? PORT_D_MASK : 8'hFF;
      // Enable term only on A, B, C, F
      assign oeTerm[p] = (p <= 2 || p == 5) ? logicOe[p*8 +: 8] : 8'h00;
      // Drive bit meaning per port
      assign slewCap[p] = (p == 2 || p == 5) ? 8'hFF : 8'h00;
      assign odCap[p] = ~slewCap[p] & validMask[p];
      always_comb begin
        // Direction 1 or enable term 1 drives
        driveNow[p].oe = (dirFlat[p*8 +: 8] | oeTerm[p]) & validMask[p];
        // Latch drives enabled pins
        driveNow[p].out = latchFlat[p*8 +: 8] & validMask[p];
        // Open drain or push-pull
        driveNow[p].openDrain = driveFlat[p*8 +: 8] & odCap[p];
        // Fast or slow slew
        driveNow[p].fastSlew = driveFlat[p*8 +: 8] & slewCap[p];
        // Mode 1 address out, 0 processor I/O
        driveNow[p].addrMode = (p >= 4) ? modeFlat[p*8 +: 8] : 8'h00;
      end
    end
  endgenerate

  // ==========================================================
  // Read multiplexer
  logic [7:0] readMux;

  always_comb begin
    readMux = 8'h00; // Unmapped and unused bits read zero
    unique case (regOfs)
      OFS_PIN_INPUT: readMux = pinIn[portIdx*8 +: 8];
      OFS_OUTPUT_LATCH: readMux = latchFlat[portIdx*8 +: 8];
      OFS_DIRECTION: readMux = dirFlat[portIdx*8 +: 8];
      OFS_DRIVE_SELECT: readMux = driveFlat[portIdx*8 +: 8];
      OFS_MODE_SELECT: begin
        if (portIdx >= PORT_E) begin
          readMux = modeFlat[portIdx*8 +: 8];
        end
      end
      OFS_CELL_ACCESS: begin
        if (portIdx <= PORT_B) begin
          readMux = cellOut[portIdx[0]*8 +: 8];
        end
      end
      OFS_CELL_MASK: begin
        if (portIdx <= PORT_B) begin
          readMux = maskFlat[portIdx[0]*8 +: 8];
        end
      end
      OFS_INPUT_CELL: begin
        if (portIdx <= PORT_C) begin
          readMux = inCellOut[portIdx*8 +: 8];
        end
      end
      OFS_OE_READBACK: begin
        if (portIdx <= PORT_C || portIdx == PORT_F) begin
          readMux = driveNow[portIdx].oe;
        end
      end
      default: readMux = 8'h00;
    endcase
    readMux = readMux & validMask[portIdx];
  end

  // ==========================================================
  // Next state: bus sequencing, cell loads, registered outputs
  always_comb begin
    next_state = state;
    next_state.rdValid = 1'b0;
    next_state.cellLoadEn = 16'h0000;
    next_state.drive = driveNow;
    // Input cells routed on to the logic input bus
    next_state.inCellBus = inCellOut;
    unique case (state.bus)
      BUS_IDLE: begin
        if (rdStb) begin
          // Capture read data now; it stands until the next read
          next_state.bus = BUS_READ;
          next_state.rdData = readMux;
          next_state.rdValid = 1'b1;
        end else if (wrStb) begin
          next_state.bus = BUS_WRITE;
          // Load only unmasked cells of A and B
          if (regOfs == OFS_CELL_ACCESS && portIdx <= PORT_B) begin
            next_state.cellLoadData[portIdx[0]*8 +: 8] = hostReq.wdata;
            next_state.cellLoadEn[portIdx[0]*8 +: 8] =
              ~maskFlat[portIdx[0]*8 +: 8];
          end
        end
      end
      BUS_WRITE: begin
        // Hold until the host drops its write strobe
        if (!hostReq.wr) begin
          next_state.bus = BUS_IDLE;
        end
      end
      BUS_READ: begin
        // Hold until the host drops its read strobe
        if (!hostReq.rd) begin
          next_state.bus = BUS_IDLE;
        end
      end
      default: next_state.bus = BUS_IDLE;
    endcase
    if (!rst_n) begin
      next_state = '0;
      next_state.bus = BUS_IDLE;
    end
  end

  // Register the whole state
  always_ff @(posedge ref_clk) begin
    state <= next_state;
  end

  // ==========================================================
  // Outputs straight from flip-flops
  assign rdData = state.rdData;
  assign rdValid = state.rdValid;
  assign pinDrive = state.drive;
  assign cellLoadData = state.cellLoadData;
  assign cellLoadEn = state.cellLoadEn;
  assign inCellBus = state.inCellBus;

endmodule
`default_nettype wire

// file: hw/io_port_pkg.sv
// Package: offsets, reset values and carrier types of the I/O port block
package io_port_pkg;

  // ==========================================================
  // Geometry
  localparam int NUM_PORTS = 7;
  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_B = 3'h1;
  localparam logic [2:0] PORT_C = 3'h2;
  localparam logic [2:0] PORT_D = 3'h3;
  localparam logic [2:0] PORT_E = 3'h4;
  localparam logic [2:0] PORT_F = 3'h5;
  localparam logic [2:0] PORT_G = 3'h6;
  localparam logic [7:0] PORT_D_MASK = 8'h0F;

  // ==========================================================
  // Register offsets inside one port's window (byte address)
  // Port n occupies base + PORT_STRIDE * n
  localparam logic [7:0] PORT_STRIDE = 8'h10;
  localparam logic [3:0] OFS_PIN_INPUT = 4'h0;
  localparam logic [3:0] OFS_OUTPUT_LATCH = 4'h1;
  localparam logic [3:0] OFS_DIRECTION = 4'h2;
  localparam logic [3:0] OFS_DRIVE_SELECT = 4'h3;
  localparam logic [3:0] OFS_MODE_SELECT = 4'h4;
  localparam logic [3:0] OFS_CELL_ACCESS = 4'h5;
  localparam logic [3:0] OFS_CELL_MASK = 4'h6;
  localparam logic [3:0] OFS_INPUT_CELL = 4'h7;
  localparam logic [3:0] OFS_OE_READBACK = 4'h8;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] openDrain;
    logic [7:0] fastSlew;
    logic [7:0] addrMode;
  } pin_drive_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ = 2'b10
  } bus_state_t;

endpackage

// file: hw/port_reg_bank.sv
// Small memory holding one byte per port for one register kind
`timescale 1ns/1ps
`default_nettype none
module port_reg_bank #(
  parameter int PORTS = 7
) (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [2:0] wrIdx, // Port written
  input wire logic wrEn, // Write strobe
  input wire logic [7:0] wrData, // Write data
  input wire logic [7:0] resetVal, // Value loaded by reset
  output logic [PORTS*8-1:0] flat // All bytes, registered
);
  import io_port_pkg::*;

  initial begin
    if (PORTS < 1 || PORTS > 8) begin
      $error("port_reg_bank: PORTS out of range");
    end
  end

  // ==========================================================
  // Storage, one byte per port
  typedef struct packed {
    logic [PORTS*8-1:0] mem;
  } bank_state_t;

  bank_state_t state;
  bank_state_t next_state;

  // Next value: reset fill or single byte write
  always_comb begin
    next_state = state;
    if (!rst_n) begin
      next_state.mem = {PORTS{resetVal}};
    end else if (wrEn && (32'(wrIdx) < PORTS)) begin
      next_state.mem[wrIdx*8 +: 8] = wrData;
    end
  end

  // Register the state
  always_ff @(posedge ref_clk) begin
    state <= next_state;
  end

  assign flat = state.mem;

endmodule
`default_nettype wire

// file: tb/io_port_regs_asserts.sv
// Checker: timing relations at the I/O port block boundary
`timescale 1ns/1ps
`default_nettype none
module io_port_regs_asserts #(
  parameter int PORTS = 7
) (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic chipSelHigh, // Chip select, high blocks
  input wire io_port_pkg::host_req_t hostReq, // Host cycle
  input wire logic rdValid, // Read pulse
  input wire logic [PORTS*8-1:0] logicOe, // Logic enables
  input wire logic [23:0] inCellOut, // Input cells
  input wire io_port_pkg::pin_drive_t [PORTS-1:0] pinDrive, // Drivers
  input wire logic [15:0] cellLoadEn, // Cell loads
  input wire logic [23:0] inCellBus // Logic input bus
);
  import io_port_pkg::*;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Bus answers
  chk_csel_block: assert property (
    chipSelHigh |=> !rdValid) else $error("answer while deselected");
  chk_read_pulse: assert property (
    rdValid |-> ($past(hostReq.rd) && !$past(chipSelHigh)) ##1 !rdValid)
    else $error("read pulse without request");
  chk_load_pulse: assert property (
    |cellLoadEn |-> $past(hostReq.wr) ##1 cellLoadEn == 16'h0000)
    else $error("cell load without write");
  chk_reset_quiet: assert property (
    !$past(rst_n) |-> !rdValid && cellLoadEn == 16'h0000)
    else $error("outputs active after reset");
  // ==========================================================
  // Pin drivers and logic input bus
  chk_oe_or: assert property ($past(rst_n) |->
    (pinDrive[0].oe & $past(logicOe[7:0])) == $past(logicOe[7:0]) &&
    (pinDrive[5].oe & $past(logicOe[47:40])) == $past(logicOe[47:40]))
    else $error("logic enable not driving");
  chk_port_d_quiet: assert property (
    pinDrive[3].oe[7:4] == 4'h0 && pinDrive[3].out[7:4] == 4'h0)
    else $error("port D upper pins active");
  chk_mode_abcd: assert property ((pinDrive[0].addrMode |
    pinDrive[1].addrMode | pinDrive[2].addrMode |
    pinDrive[3].addrMode) == 8'h00) else $error("mode on port A to D");
  chk_slew_map: assert property (pinDrive[2].openDrain == 8'h00 &&
    pinDrive[5].openDrain == 8'h00 && pinDrive[0].fastSlew == 8'h00)
    else $error("drive bit meaning wrong");
  chk_incell_lag: assert property (
    $past(rst_n) |-> inCellBus == $past(inCellOut))
    else $error("input cell bus not following");
endmodule
bind io_port_regs io_port_regs_asserts #(.PORTS(PORTS)) i_io_port_regs_asserts (
  .ref_clk, .rst_n, .chipSelHigh, .hostReq, .rdValid, .logicOe,
  .inCellOut, .pinDrive, .cellLoadEn, .inCellBus);
`default_nettype wire

// file: tb/host_bus_model.sv
// Host bus master model: plain read and write cycles
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input wire logic ref_clk, // Clock
  output var io_port_pkg::host_req_t hostReq // Request to block
);
  import io_port_pkg::*;
  // Idle bus at time zero
  initial begin
    hostReq = '0;
  end
  // Write held to the taking edge, lines scrambled on release
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    hostReq <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk);
    hostReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // Read held to the taking edge
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    hostReq <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    hostReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
  endtask
endmodule
`default_nettype wire

// file: tb/configurable_io_port_registers_test.sv
// Self-checking bench for the I/O port register block
`timescale 1ns/1ps
`default_nettype none
module configurable_io_port_registers_test;
  import io_port_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic chipSelHigh = 1'b0;
  logic [55:0] pinIn = '0;
  logic [55:0] logicOe = '0;
  logic [15:0] cellOut = '0;
  logic [23:0] inCellOut = '0;
  host_req_t hostReq;
  logic [7:0] rdData;
  logic rdValid;
  pin_drive_t [6:0] pinDrive;
  logic [15:0] cellLoadEn;
  logic [15:0] cellLoadData;
  logic [23:0] inCellBus;
  logic [7:0] expQ [$];
  logic [7:0] v;
  logic [7:0] m;
  logic [7:0] dirV [7];
  logic [7:0] drvV [7];
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  // Clock of 5 ns
  always #2.5 ref_clk = ~ref_clk;
  io_port_regs i_io_port_regs (.ref_clk, .rst_n, .chipSelHigh, .hostReq,
    .rdData, .rdValid, .pinIn, .logicOe, .cellOut, .inCellOut, .pinDrive,
    .cellLoadData, .cellLoadEn, .inCellBus);
  host_bus_model host (.ref_clk, .hostReq);
  // ==========================================================
  // Compare, report and close
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Note the expected read data, then run the read
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host.rd(a);
  endtask
  // Read answers against the oldest note
  always @(posedge ref_clk) begin
    if (rdValid === 1'b1) begin
      chk(rdData, (expQ.size() > 0) ? expQ.pop_front() : 8'hXX);
    end
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      close_out();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    v = 8'($urandom(32'h581F));
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    pinIn <= 56'({$urandom, $urandom});
    logicOe <= 56'({$urandom, $urandom});
    cellOut <= 16'($urandom);
    inCellOut <= 24'($urandom);
    // Reset values of every port
    for (int p = 0; p < 7; p++) begin
      rdx(8'(p * 16 + 2), 8'h00);
      rdx(8'(p * 16 + 3), 8'h00);
      rdx(8'(p * 16 + 4), 8'h00);
      rdx(8'(p * 16 + 6), 8'h00);
    end
    // Random configuration, read back and pin drivers
    for (int p = 0; p < 7; p++) begin
      m = (p == 3) ? PORT_D_MASK : 8'hFF;
      dirV[p] = 8'($urandom);
      drvV[p] = 8'($urandom);
      v = 8'($urandom);
      host.wr(8'(p * 16 + 2), dirV[p]);
      host.wr(8'(p * 16 + 3), drvV[p]);
      host.wr(8'(p * 16 + 4), v);
      host.wr(8'(p * 16 + 1), v);
      rdx(8'(p * 16 + 2), dirV[p] & m);
      rdx(8'(p * 16 + 3), drvV[p] & m);
      rdx(8'(p * 16 + 4), (p > 3) ? v : 8'h00);
      rdx(8'(p * 16 + 1), v & m);
      rdx(8'(p * 16), pinIn[p * 8 +: 8] & m);
      #1;
      chk(pinDrive[p].addrMode, (p > 3) ? v : 8'h00);
      chk(pinDrive[p].out, v & m);
      if (p == 2 || p == 5) begin
        chk(pinDrive[p].fastSlew, drvV[p]);
      end else begin
        chk(pinDrive[p].openDrain, drvV[p] & m);
      end
      if (p inside {0, 1, 2, 5}) begin
        chk(pinDrive[p].oe, dirV[p] | logicOe[p * 8 +: 8]);
        rdx(8'(p * 16 + 8), dirV[p] | logicOe[p * 8 +: 8]);
      end else begin
        chk(pinDrive[p].oe, dirV[p] & m);
      end
    end
    // Output cells with load mask, input cells
    for (int p = 0; p < 2; p++) begin
      m = 8'($urandom);
      v = 8'($urandom);
      host.wr(8'(p * 16 + 6), m);
      rdx(8'(p * 16 + 6), m);
      host.wr(8'(p * 16 + 5), v);
      #1;
      chk(cellLoadEn[p * 8 +: 8], ~m);
      chk(cellLoadData[p * 8 +: 8], v);
      rdx(8'(p * 16 + 5), cellOut[p * 8 +: 8]);
    end
    for (int p = 0; p < 3; p++) begin
      rdx(8'(p * 16 + 7), inCellOut[p * 8 +: 8]);
      chk(inCellBus[p * 8 +: 8], inCellOut[p * 8 +: 8]);
    end
    rdx(8'h25, 8'h00);
    // Deselected and unmapped cycles leave no trace
    chipSelHigh <= 1'b1;
    host.wr(8'h02, ~dirV[0]);
    host.rd(8'h02);
    @(posedge ref_clk);
    chipSelHigh <= 1'b0;
    rdx(8'h02, dirV[0]);
    host.rd(8'h75);
    host.wr(8'h72, 8'hFF);
    repeat (4) @(posedge ref_clk);
    chk(8'(expQ.size()), 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
